// ---- design/acst_ctrl.sv ----
`timescale 1ns/1ps
module acst_ctrl #(
  parameter logic [2:0] ADD_CNT = acst_pkg::ADD_CNT_DEF
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // scan control
  input  wire logic        scan_start_bit,
  input  wire logic        clock_speed_select,
  input  wire logic        continuous_scan,
  input  wire logic [23:0] scan_ch_select,
  input  wire logic [23:0] add_mode_select,
  // triggers
  input  wire logic        trigger_enable_bit,
  input  wire logic        external_trigger_select,
  input  wire logic        external_trigger_pin,
  input  wire logic [1:0]  timer_scan_trig,
  input  wire logic [23:0] intconv_req,
  // monitor pin selection
  input  wire logic        monitor_a_select,
  input  wire logic        monitor_b_select,
  // scan end handling
  input  wire logic        scan_end_irq_enable,
  input  wire logic        scan_end_to_dma,
  input  wire logic        scan_end_flag_clear,
  input  wire logic        scan_end_dma_ack,
  // channel done handling
  input  wire logic [23:0] channel_done_irq_enable,
  input  wire logic        done_flags_read,
  input  wire logic        done_flags_write,
  input  wire logic [23:0] done_flags_wdata,
  input  wire logic [7:0]  main_dma_ack,
  input  wire logic        second_dma_ack,
  // status and pins
  output logic             scan_active_bit,
  output logic             scan_end_flag,
  output logic             scan_end_irq,
  output logic             scan_end_dma_req,
  output logic             unit_a_monitor_out,
  output logic             unit_b_monitor_out,
  output logic      [23:0] channel_done_flag,
  output logic      [23:0] channel_done_irq
);

  typedef struct packed {
    acst_pkg::acst_state_t st;
    logic [5:0]  cnt;
    logic        speed;
    logic        cont;
    logic        resume;
    logic        active;
    logic        start_q;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_s3;
    logic [2:0]  tcnt;
    logic [2:0]  rep;
    logic [4:0]  ch;
    logic [4:0]  ich;
    logic [23:0] ipend;
    logic [23:0] idone;
    logic        end_flag;
    logic        end_irq;
    logic        end_dma;
    logic        mon_a;
    logic        mon_b;
  } acst_ctrl_t;

  acst_ctrl_t r;
  acst_ctrl_t n;

  logic       sw_rise;
  logic       sw_fall;
  logic       fall_det;
  logic       ext_en;
  logic       tim_go;
  logic       go;
  logic       take_int;
  logic [5:0] pick_first;
  logic [5:0] pick_next;
  logic [5:0] ipick;

  //////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] dur(acst_pkg::acst_state_t s,
                                     logic hs);
    case (s)
      acst_pkg::ST_START: begin
        dur = hs ? acst_pkg::HS_T_D : acst_pkg::LS_T_D;
      end
      acst_pkg::ST_SAMPLE, acst_pkg::ST_ISAMPLE: begin
        dur = hs ? acst_pkg::HS_T_SPL : acst_pkg::LS_T_SPL;
      end
      acst_pkg::ST_CONV, acst_pkg::ST_ICONV: begin
        dur = hs ? acst_pkg::HS_T_CONV : acst_pkg::LS_T_CONV;
      end
      acst_pkg::ST_END: begin
        dur = hs ? acst_pkg::HS_T_ED : acst_pkg::LS_T_ED;
      end
      default: begin
        dur = 6'h01;
      end
    endcase
  endfunction : dur

  // lowest selected channel at or above from; bit 5 set when none
  function automatic logic [5:0] first_from(logic [23:0] sel,
                                            logic [5:0]  from);
    first_from = 6'h20;
    for (int i = acst_pkg::NCH - 1; i >= 0; i--) begin
      if (sel[i] && 6'(i) >= from) begin
        first_from = 6'(i);
      end
    end
  endfunction : first_from

  function automatic logic [2:0] rep_last(logic add);
    rep_last = add ? ADD_CNT - 3'h1 : 3'h0;
  endfunction : rep_last

  //////////////////////////////////////////////////////////////////////
  // pin goes through three flops; the second and third are compared
  assign fall_det   = r.ext_s3 && !r.ext_s2;
  assign ext_en     = trigger_enable_bit && external_trigger_select;
  assign tim_go     = (|timer_scan_trig) && !trigger_enable_bit &&
                      !external_trigger_select;
  assign sw_rise    = scan_start_bit && !r.start_q;
  assign sw_fall    = !scan_start_bit && r.start_q;
  // every start source enters the same start path
  assign go         = sw_rise || tim_go || r.tcnt == 3'h1;
  assign pick_first = first_from(scan_ch_select, 6'h00);
  assign pick_next  = first_from(scan_ch_select, {1'b0, r.ch} + 6'h01);
  // ascending order; unit b's own priority order is not modelled
  assign ipick      = first_from(r.ipend, 6'h00);

  always_comb begin
    n          = r;
    take_int   = 1'b0;
    n.start_q  = scan_start_bit;
    n.ext_s1   = external_trigger_pin;
    n.ext_s2   = r.ext_s1;
    n.ext_s3   = r.ext_s2;
    n.idone    = 24'h000000;
    n.ipend    = r.ipend | intconv_req;
    if (scan_end_flag_clear || scan_end_dma_ack) begin
      n.end_flag = 1'b0;
    end
    // latency after the sampled edge, per speed
    if (r.tcnt != 3'h0) begin
      n.tcnt = r.tcnt - 3'h1;
    end else if (fall_det && ext_en && !r.active) begin
      n.tcnt = (clock_speed_select ? acst_pkg::HS_TRIG_LAT :
                acst_pkg::LS_TRIG_LAT) - 3'h1;
    end
    if (r.cnt != 6'h00) begin
      n.cnt = r.cnt - 6'h01;
    end
    if (!r.active && go) begin
      n.active = 1'b1;
      n.speed  = clock_speed_select;
      n.cont   = continuous_scan;
      n.resume = 1'b0;
    end
    case (r.st)
      acst_pkg::ST_IDLE: begin
        if (n.active && !r.active) begin
          n.st = acst_pkg::ST_START;
        end else if (|r.ipend) begin
          take_int = 1'b1;
        end
      end
      acst_pkg::ST_START: begin
        if (r.cnt == 6'h00) begin
          if (pick_first[5]) begin
            n.st     = acst_pkg::ST_IDLE;
            n.active = 1'b0;
          end else begin
            n.st  = acst_pkg::ST_SAMPLE;
            n.ch  = pick_first[4:0];
            n.rep = 3'h0;
          end
        end
      end
      acst_pkg::ST_SAMPLE: begin
        if (|r.ipend) begin
          take_int = 1'b1;
          n.resume = 1'b1;
        end else if (r.cnt == 6'h00) begin
          n.st = acst_pkg::ST_CONV;
        end
      end
      acst_pkg::ST_CONV: begin
        if (|r.ipend) begin
          // suspended channel is redone in full afterwards
          take_int = 1'b1;
          n.resume = 1'b1;
        end else if (r.cnt == 6'h00) begin
          n.rep = 3'h0;
          n.st  = acst_pkg::ST_SAMPLE;
          if (r.rep != rep_last(add_mode_select[r.ch])) begin
            n.rep = r.rep + 3'h1;
          end else if (!pick_next[5]) begin
            n.ch = pick_next[4:0];
          end else if (r.cont) begin
            n.ch       = pick_first[4:0];
            n.end_flag = 1'b1;
          end else begin
            n.st = acst_pkg::ST_END;
          end
        end
      end
      acst_pkg::ST_END: begin
        if (r.cnt == 6'h00) begin
          n.st       = acst_pkg::ST_IDLE;
          n.active   = 1'b0;
          n.end_flag = 1'b1;
        end
      end
      acst_pkg::ST_ISAMPLE: begin
        if (r.cnt == 6'h00) begin
          n.st = acst_pkg::ST_ICONV;
        end
      end
      acst_pkg::ST_ICONV: begin
        if (r.cnt == 6'h00) begin
          if (r.rep != rep_last(add_mode_select[r.ich])) begin
            n.st  = acst_pkg::ST_ISAMPLE;
            n.rep = r.rep + 3'h1;
          end else begin
            n.idone[r.ich] = 1'b1;
            n.rep          = 3'h0;
            if (|r.ipend) begin
              take_int = 1'b1;
            end else if (n.active) begin
              n.st = n.resume ? acst_pkg::ST_SAMPLE :
                     acst_pkg::ST_START;
            end else begin
              n.st = acst_pkg::ST_IDLE;
            end
          end
        end
      end
      default: begin
        n.st = acst_pkg::ST_IDLE;
      end
    endcase
    if (take_int) begin
      n.st              = acst_pkg::ST_ISAMPLE;
      n.ich             = ipick[4:0];
      n.rep             = 3'h0;
      n.ipend[ipick[4:0]] = 1'b0;
      // an idle interrupt conversion runs at the current speed
      if (!n.active) begin
        n.speed = clock_speed_select;
      end
    end
    // abort cuts the scan; a running interrupt conversion finishes
    if (r.active && sw_fall) begin
      n.active = 1'b0;
      n.resume = 1'b0;
      if (n.st inside {acst_pkg::ST_START, acst_pkg::ST_SAMPLE,
                       acst_pkg::ST_CONV, acst_pkg::ST_END}) begin
        n.st = acst_pkg::ST_IDLE;
      end
    end
    if (n.st != r.st) begin
      n.cnt = dur(n.st, n.speed) - 6'h01;
    end
    // preemption moves the state away, so the pin drops for it
    n.mon_a = monitor_a_select &&
              ((n.st == acst_pkg::ST_CONV &&
                n.ch == acst_pkg::CH_A_FIRST &&
                n.rep == rep_last(add_mode_select[n.ch])) ||
               (n.st == acst_pkg::ST_ICONV &&
                n.ich == acst_pkg::CH_A_FIRST &&
                n.rep == rep_last(add_mode_select[n.ich])));
    n.mon_b = monitor_b_select &&
              ((n.st == acst_pkg::ST_CONV &&
                n.ch == acst_pkg::CH_B_FIRST &&
                n.rep == rep_last(add_mode_select[n.ch])) ||
               (n.st == acst_pkg::ST_ICONV &&
                n.ich == acst_pkg::CH_B_FIRST &&
                n.rep == rep_last(add_mode_select[n.ich])));
    n.end_irq = n.end_flag && scan_end_irq_enable &&
                !scan_end_to_dma;
    n.end_dma = n.end_flag && scan_end_to_dma;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign scan_active_bit    = r.active;
  assign scan_end_flag      = r.end_flag;
  assign scan_end_irq       = r.end_irq;
  assign scan_end_dma_req   = r.end_dma;
  assign unit_a_monitor_out = r.mon_a;
  assign unit_b_monitor_out = r.mon_b;

  //////////////////////////////////////////////////////////////////////
  acst_flags u_flags (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .done_set (r.idone),
    .dma_clr  ({main_dma_ack, 15'h0000, second_dma_ack}),
    .irq_en   (channel_done_irq_enable),
    .sw_rd    (done_flags_read),
    .sw_wr    (done_flags_write),
    .sw_wdata (done_flags_wdata),
    .flags    (channel_done_flag),
    .irq      (channel_done_irq)
  );

  //////////////////////////////////////////////////////////////////////
  logic [7:0] hold_len;

  always_ff @(posedge clk) begin
    if (sys_rst || n.st != r.st) begin
      hold_len <= 8'h00;
    end else begin
      hold_len <= hold_len + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_start_dly;
    (r.st == acst_pkg::ST_SAMPLE && $past(r.st) == acst_pkg::ST_START)
      |-> $past(hold_len) == {2'h0, dur(acst_pkg::ST_START, r.speed)}
          - 8'h01;
  endproperty
  a_start_dly: assert property (p_start_dly)
    else $error("start delay length wrong");

  property p_sample_len;
    (r.st == acst_pkg::ST_CONV && $past(r.st) == acst_pkg::ST_SAMPLE)
      |-> $past(hold_len) == {2'h0, dur(acst_pkg::ST_SAMPLE, r.speed)}
          - 8'h01;
  endproperty
  a_sample_len: assert property (p_sample_len)
    else $error("sampling length wrong");

  property p_conv_len;
    ($past(r.st) == acst_pkg::ST_CONV &&
     r.st inside {acst_pkg::ST_SAMPLE, acst_pkg::ST_END})
      |-> $past(hold_len) == {2'h0, dur(acst_pkg::ST_CONV, r.speed)}
          - 8'h01;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");

  property p_end_dly;
    (r.st == acst_pkg::ST_IDLE && $past(r.st) == acst_pkg::ST_END)
      |-> r.end_flag && !r.active &&
          $past(hold_len) == {2'h0, dur(acst_pkg::ST_END, r.speed)}
          - 8'h01;
  endproperty
  a_end_dly: assert property (p_end_dly)
    else $error("scan end not flagged after end delay");

  property p_cont;
    (r.cont && r.active) |-> r.st != acst_pkg::ST_END;
  endproperty
  a_cont: assert property (p_cont)
    else $error("end delay in continuous scan");

  property p_ext_lo;
    (fall_det && ext_en && !r.active && r.tcnt == 3'h0 &&
     !clock_speed_select) |-> ##4 r.active;
  endproperty
  a_ext_lo: assert property (p_ext_lo)
    else $error("low speed trigger latency wrong");

  property p_ext_hi;
    (fall_det && ext_en && !r.active && r.tcnt == 3'h0 &&
     clock_speed_select) |-> ##1 !r.active ##1 !r.active ##1 r.active;
  endproperty
  a_ext_hi: assert property (p_ext_hi)
    else $error("high speed trigger latency wrong");

  property p_timer;
    (tim_go && !r.active) |=> r.active && r.st == acst_pkg::ST_START;
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer trigger did not start scan");

  property p_abort;
    (r.active && sw_fall) |=> !r.active;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort sequence ignored");

  property p_mon;
    unit_a_monitor_out |-> monitor_a_select ##0
      ((r.st == acst_pkg::ST_CONV && r.ch == acst_pkg::CH_A_FIRST) ||
       (r.st == acst_pkg::ST_ICONV && r.ich == acst_pkg::CH_A_FIRST));
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor high outside first channel conversion");

  property p_irq;
    scan_end_irq |-> r.end_flag && $past(scan_end_irq_enable) &&
                     !$past(scan_end_to_dma);
  endproperty
  a_irq: assert property (p_irq)
    else $error("scan end request not gated");

  property p_hold;
    (r.end_flag && !scan_end_flag_clear && !scan_end_dma_ack)
      |=> r.end_flag;
  endproperty
  a_hold: assert property (p_hold)
    else $error("scan end flag lost");

  c_scan_end: cover property (r.st == acst_pkg::ST_END ##1
                              r.st == acst_pkg::ST_IDLE);
  c_ext_start: cover property (fall_det && ext_en ##4 r.active);
  c_preempt: cover property (r.st == acst_pkg::ST_CONV ##1
                             r.st == acst_pkg::ST_ISAMPLE);
  c_mon_a: cover property ($rose(unit_a_monitor_out));

endmodule : acst_ctrl

// ---- include/acst_pkg.sv ----
package acst_pkg;

  localparam int NCH = 24;

  // channel index of each unit's monitored channel
  localparam logic [4:0] CH_A_FIRST = 5'h00;
  localparam logic [4:0] CH_B_FIRST = 5'h10;

  // phase lengths in peripheral clock states, low speed
  localparam logic [5:0] LS_T_D    = 6'h07;
  localparam logic [5:0] LS_T_SPL  = 6'h14;
  localparam logic [5:0] LS_T_CONV = 6'h1e;
  localparam logic [5:0] LS_T_ED   = 6'h04;
  // phase lengths in peripheral clock states, high speed
  localparam logic [5:0] HS_T_D    = 6'h05;
  localparam logic [5:0] HS_T_SPL  = 6'h0a;
  localparam logic [5:0] HS_T_CONV = 6'h0f;
  localparam logic [5:0] HS_T_ED   = 6'h02;

  // external trigger latency after the sampled falling edge
  localparam logic [2:0] LS_TRIG_LAT = 3'h4;
  localparam logic [2:0] HS_TRIG_LAT = 3'h3;

  // conversions accumulated in value-addition mode
  localparam logic [2:0] ADD_CNT_DEF = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_START   = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONV    = 3'b011,
    ST_END     = 3'b100,
    ST_ISAMPLE = 3'b101,
    ST_ICONV   = 3'b110
  } acst_state_t;

endpackage : acst_pkg

// ---- design/acst_flags.sv ----
`timescale 1ns/1ps
module acst_flags (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // events and irq enables
  input  wire logic [23:0] done_set,
  input  wire logic [23:0] dma_clr,
  input  wire logic [23:0] irq_en,
  // software access
  input  wire logic        sw_rd,
  input  wire logic        sw_wr,
  input  wire logic [23:0] sw_wdata,
  // status
  output logic      [23:0] flags,
  output logic      [23:0] irq
);

  typedef struct packed {
    logic [23:0] flags;
    logic [23:0] armed;
    logic [23:0] irq;
  } acst_flags_t;

  acst_flags_t r;
  acst_flags_t n;
  logic [23:0] f_n;
  logic [23:0] a_n;

  //////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < acst_pkg::NCH; i++) begin : g_bit
    logic clr;
    // a write of 0 only clears a bit first seen as 1 by a read
    assign clr = (sw_wr && r.armed[i] && !sw_wdata[i]) || dma_clr[i];
    // set wins over any clear in the same cycle
    assign f_n[i] = done_set[i] || (r.flags[i] && !clr);
    assign a_n[i] = (sw_rd && r.flags[i]) ||
                    (r.armed[i] && !sw_wr && f_n[i]);
  end

  always_comb begin
    n       = r;
    n.flags = f_n;
    n.armed = a_n;
    // the request to the cpu never touches the flag
    n.irq   = f_n & irq_en;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign flags = r.flags;
  assign irq   = r.irq;

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_clear_needs_read;
    (r.flags & ~f_n & ~dma_clr & ~r.armed) == 24'h000000;
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read)
    else $error("flag cleared without a prior read of 1");

  property p_irq_keeps_flag;
    (!sw_wr && dma_clr == 24'h000000) |=>
      ((r.flags & $past(r.flags)) == $past(r.flags));
  endproperty
  a_irq_keeps_flag: assert property (p_irq_keeps_flag)
    else $error("flag dropped without write or dma");

  property p_dma_clear;
    (|(dma_clr & ~done_set)) |=>
      ((r.flags & $past(dma_clr & ~done_set)) == 24'h000000);
  endproperty
  a_dma_clear: assert property (p_dma_clear)
    else $error("dma transfer did not clear flag");

endmodule : acst_flags

// ---- bench/acst_far.sv ----
`timescale 1ns/1ps
module acst_far (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // dma setup
  input  wire logic        en,
  input  wire logic [3:0]  dly,
  // requests
  input  wire logic        scan_end_dma_req,
  input  wire logic [23:0] channel_done_irq,
  // acknowledges
  output logic             scan_end_dma_ack,
  output logic      [7:0]  main_dma_ack,
  output logic             second_dma_ack
);
  logic [9:0] req;
  logic [3:0] cnt_reg;
  logic       hold_reg;
  // only channels 16-23, channel 0 and scan end can start a transfer
  assign req = {channel_done_irq[23:16], channel_done_irq[0],
                scan_end_dma_req} & {10{en}};
  // one transfer per request; the request drops a cycle after the ack, so wait for it to drop
  always_ff @(posedge clk) begin
    {main_dma_ack, second_dma_ack, scan_end_dma_ack} <= 10'h000;
    if (sys_rst || req == 10'h000) begin
      cnt_reg  <= 4'h0;
      hold_reg <= 1'b0;
    end else if (!hold_reg && cnt_reg == dly) begin
      {main_dma_ack, second_dma_ack, scan_end_dma_ack} <= req;
      hold_reg <= 1'b1;
    end else if (!hold_reg) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : acst_far

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        clk, sys_rst, start, hs, cont, te, ets, pin, mon_a, mon_b;
  logic        se_en, se_dma, se_clr, se_ack, rd, wr, sec_ack, dma_en;
  logic        act, sef, seirq, sereq, ua, ub;
  logic [1:0]  tmr;
  logic [3:0]  dly;
  logic [7:0]  m_ack;
  logic [23:0] sel, addm, icr, cde, wd, cdf, cdi;
  int          err_total, num_checks, n, k, h, t0, t1, mh, mr;

  acst_ctrl uut (.clk(clk), .sys_rst(sys_rst), .scan_start_bit(start),
    .clock_speed_select(hs), .continuous_scan(cont), .scan_ch_select(sel),
    .add_mode_select(addm), .trigger_enable_bit(te),
    .external_trigger_select(ets), .external_trigger_pin(pin),
    .timer_scan_trig(tmr), .intconv_req(icr), .monitor_a_select(mon_a),
    .monitor_b_select(mon_b), .scan_end_irq_enable(se_en),
    .scan_end_to_dma(se_dma), .scan_end_flag_clear(se_clr),
    .scan_end_dma_ack(se_ack), .channel_done_irq_enable(cde),
    .done_flags_read(rd), .done_flags_write(wr), .done_flags_wdata(wd),
    .main_dma_ack(m_ack), .second_dma_ack(sec_ack), .scan_active_bit(act),
    .scan_end_flag(sef), .scan_end_irq(seirq), .scan_end_dma_req(sereq),
    .unit_a_monitor_out(ua), .unit_b_monitor_out(ub),
    .channel_done_flag(cdf), .channel_done_irq(cdi));

  acst_far far (.clk(clk), .sys_rst(sys_rst), .en(dma_en), .dly(dly),
    .scan_end_dma_req(sereq), .channel_done_irq(cdi),
    .scan_end_dma_ack(se_ack), .main_dma_ack(m_ack),
    .second_dma_ack(sec_ack));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // model: phase lengths and scan times from speed and channel count
  function automatic int ph(input logic f, input int i);
    case (i)
      0: return f ? acst_pkg::HS_T_D : acst_pkg::LS_T_D;
      1: return f ? acst_pkg::HS_T_SPL : acst_pkg::LS_T_SPL;
      2: return f ? acst_pkg::HS_T_CONV : acst_pkg::LS_T_CONV;
      3: return f ? acst_pkg::HS_T_ED : acst_pkg::LS_T_ED;
      default: return f ? acst_pkg::HS_TRIG_LAT : acst_pkg::LS_TRIG_LAT;
    endcase
  endfunction : ph

  function automatic int ts(input logic f, input int c);
    return ph(f, 0) + c * (ph(f, 1) + ph(f, 2)) + ph(f, 3);
  endfunction : ts

  function automatic logic sig(input int w);
    return w == 0 ? act : w == 1 ? sef : cdf[w-2];
  endfunction : sig

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic finish_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  // bounded wait; also counts monitor high cycles and rises on the way
  task automatic wt(input int w, input logic v, output int c);
    logic p;
    c = 0;
    p = ua | ub;
    while (sig(w) !== v) begin
      tick();
      c++;
      if ((ua | ub) === 1'b1) mh++;
      if ((ua | ub) === 1'b1 && p !== 1'b1) mr++;
      p = ua | ub;
      if (c > 2000) begin
        chk(1'b0, "wait ran out");
        finish_test();
      end
    end
  endtask : wt

  task automatic clr_se();
    se_clr = 1'b1;
    tick();
    se_clr = 1'b0;
    tick();
    chk(sef === 1'b0, "scan end flag not cleared");
  endtask : clr_se

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {start, hs, cont, te, ets, mon_a, mon_b, se_en, se_dma} = 9'h000;
    {se_clr, rd, wr, dma_en, tmr} = 5'h00;
    {sel, addm, icr, cde, wd} = {5{24'h000000}};
    pin = 1'b1;
    dly = 4'h1;
    err_total = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    k = $urandom(32'he1f0059e);
    repeat (5) tick();
    sys_rst = 1'b0;
    repeat (3) tick();
    // single scans on random channels, both speeds, irq on and off
    for (k = 0; k < 4; k++) begin
      hs = k[0];
      se_en = k[1];
      sel = (24'h1 << ($urandom % 24)) | (24'h1 << ($urandom % 24));
      n = $countones(sel);
      start = 1'b1;
      wt(0, 1'b1, t0);
      wt(0, 1'b0, t1);
      chk(t1 == ts(hs, n), "scan time");
      chk(sef === 1'b1, "flag not set at scan end");
      chk(seirq === se_en, "scan end irq gating");
      start = 1'b0;
      repeat (2) tick();
      chk(sef === 1'b1, "flag lost by irq");
      clr_se();
    end
    // continuous scan served by dma, then aborted
    {hs, cont, se_dma, dma_en, sel} = {4'h7, 24'h000003};
    start = 1'b1;
    wt(0, 1'b1, t0);
    wt(1, 1'b1, t0);
    chk(t0 == ts(0, 2) - ph(0, 3), "first cycle");
    chk(seirq === 1'b0 && sereq === 1'b1, "dma routing");
    wt(1, 1'b0, k);
    wt(1, 1'b1, t1);
    chk(k + t1 == 2 * (ph(0, 1) + ph(0, 2)), "later cycle");
    start = 1'b0;
    tick();
    chk(act === 1'b0, "abort ignored");
    // let the dma take the last flag before it is switched off
    wt(1, 1'b0, k);
    {cont, se_dma, dma_en} = 3'h0;
    repeat (220) tick();
    chk({act, sef} === 2'b00, "scan ran on after abort");
    // external trigger at both speeds; pin held high while enabling
    {te, ets, sel} = {2'h3, 24'h000001};
    for (h = 0; h < 2; h++) begin
      hs = h[0];
      repeat (3) tick();
      pin = 1'b0;
      wt(0, 1'b1, t0);
      chk(t0 == ph(hs, 4) + 2, "latency");
      wt(0, 1'b0, t1);
      chk(t1 == ts(hs, 1), "hw start timing");
      pin = 1'b1;
      clr_se();
    end
    // timer trigger refused with trigger enable set, taken with both 0
    tmr = 2'b01;
    tick();
    tmr = 2'b00;
    repeat (8) tick();
    chk(act === 1'b0, "timer start while enabled");
    {te, ets, tmr} = 4'h2;
    tick();
    tmr = 2'b00;
    wt(0, 1'b1, t0);
    chk(t0 == 0, "timer start late");
    wt(0, 1'b0, t1);
    chk(t1 == ts(hs, 1), "timer start timing");
    clr_se();
    // interrupt conversions on the two monitored channels
    {mon_a, mon_b, addm, cde} = {2'h3, 24'h000001, 24'h010000};
    for (h = 0; h < 17; h += 16) begin
      dma_en = (h == 16);
      icr[h] = 1'b1;
      tick();
      icr = 24'h000000;
      mh = 0;
      mr = 0;
      wt(2 + h, 1'b1, t0);
      chk(mh == ph(hs, 2) && mr == 1, "monitor pulse");
      tick();
      chk(cdi[h] === cde[h], "done irq");
      chk(cdf[h] === 1'b1, "flag lost by done irq");
    end
    repeat (8) tick();
    chk(cdf[16] === 1'b0, "dma did not clear");
    wr = 1'b1;
    tick();
    wr = 1'b0;
    tick();
    chk(cdf[0] === 1'b1, "cleared without read");
    rd = 1'b1;
    tick();
    {rd, wr} = 2'b01;
    tick();
    wr = 1'b0;
    tick();
    chk(cdf[0] === 1'b0, "read then write 0");
    // scan on the monitored channel, preempted by its own interrupt
    {sel, addm, cde} = {24'h000001, 24'h000000, 24'h000001};
    start = 1'b1;
    wt(0, 1'b1, t0);
    repeat (ph(hs, 0) + ph(hs, 1) + 2) tick();
    chk(ua === 1'b1, "monitor low in scan conversion");
    icr[0] = 1'b1;
    tick();
    icr = 24'h000000;
    tick();
    chk(ua === 1'b0, "monitor kept through preemption");
    mh = 0;
    mr = 0;
    wt(0, 1'b0, t1);
    chk(mh == 2 * ph(hs, 2) && mr == 2, "monitor reconversion");
    chk(cdf[0] === 1'b0, "second dma did not clear");
    finish_test();
  end
endmodule : tb
